// [src/mode_scheduler.sv]
// Purpose: per-granule mode scheduler with sequence and schedule memories
// Assumes: bunch_i is valid in the cycle of cross_i
// Notes:   a repeat count of zero plays the sequence once
`default_nettype none
module mode_scheduler
    import trig_pkg::*;
#(
    parameter int MW = MODE_WIDTH
) (
    // clock and control
    input  wire logic          clk_i,
    input  wire logic          rst_i,
    input  wire logic          ce_i,
    // crossing
    input  wire logic          run_i,
    input  wire logic          cross_i,
    input  wire logic [6:0]    bunch_i,
    // schedule memory port
    input  wire logic          sch_we_i,
    input  wire logic [6:0]    sch_addr_i,
    input  wire logic [31:0]   sch_wdata_i,
    input  wire logic [6:0]    sch_raddr_i,
    output logic      [31:0]   sch_rdata_o,
    // sequence memory port
    input  wire logic          seq_we_i,
    input  wire logic [4:0]    seq_sel_i,
    input  wire logic [6:0]    seq_bunch_i,
    input  wire logic [MW-1:0] seq_wdata_i,
    // front-end mode
    output logic      [MW-1:0] mode_o
);
    logic [31:0]     sched_mem [SCHED_DEPTH];
    logic [MW-1:0]   seq_mem   [NUM_SEQ][SEQ_LEN];
    sched_state_type state_reg;
    logic [6:0]      ptr_reg;
    logic [6:0]      ptr_next;
    logic [25:0]     rem_reg;
    logic            restart_reg;
    logic [4:0]      seq_reg;
    logic [4:0]      seq_next;
    logic [31:0]     entry;
    logic            boundary;
    logic            advance;

    assign boundary = cross_i && run_i && (bunch_i == BUNCH_FIRST);
    assign advance  = boundary &&
        ((state_reg == SCH_WAIT) || (rem_reg <= 26'h1));

    always_comb begin
        ptr_next = 7'h00;
        case (state_reg)
            SCH_WAIT: ptr_next = 7'h00;
            SCH_PLAY: ptr_next = restart_reg ? 7'h00 : ptr_reg + 7'h01;
            default:  ptr_next = 7'h00;
        endcase
    end

    assign entry       = sched_mem[ptr_next];
    assign seq_next    = advance ? entry[SEQ_IDX_MSB:SEQ_IDX_LSB] : seq_reg;
    assign sch_rdata_o = sched_mem[sch_raddr_i];

    always_ff @(posedge clk_i) begin
        if (ce_i && sch_we_i) begin
            sched_mem[sch_addr_i] <= sch_wdata_i;
        end
        if (ce_i && seq_we_i && seq_bunch_i < 7'(SEQ_LEN)) begin
            seq_mem[seq_sel_i][seq_bunch_i] <= seq_wdata_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg   <= SCH_WAIT;
            ptr_reg     <= 7'h00;
            rem_reg     <= 26'h0;
            restart_reg <= 1'b0;
            seq_reg     <= 5'h00;
        end else if (ce_i && advance) begin
            state_reg   <= SCH_PLAY;
            ptr_reg     <= ptr_next;
            rem_reg     <= entry[REPEAT_MSB:REPEAT_LSB];
            restart_reg <= entry[RESTART_BIT];
            seq_reg     <= entry[SEQ_IDX_MSB:SEQ_IDX_LSB];
        end else if (ce_i && boundary) begin
            rem_reg <= rem_reg - 26'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode_o <= '0;
        end else if (ce_i && cross_i && run_i) begin
            mode_o <= seq_mem[seq_next][bunch_i];
        end
    end

    a_entry_on_boundary: assert property (
        @(posedge clk_i iff ce_i) disable iff (rst_i)
        !boundary |=> $stable(ptr_reg) && $stable(seq_reg))
        else $error("sequence changed inside a revolution");
    a_restart_jump: assert property (
        @(posedge clk_i iff ce_i) disable iff (rst_i)
        advance && state_reg == SCH_PLAY && restart_reg |=> ptr_reg == 7'h00)
        else $error("restart entry did not return to entry zero");
endmodule : mode_scheduler
`default_nettype wire

// [src/scaledown_path.sv]
// Purpose: one trigger input's scaledown counter
// Assumes: cross_i is a one-cycle crossing strobe
// Notes:   a setting of zero behaves like one
`default_nettype none
module scaledown_path
    import trig_pkg::*;
#(
    parameter int SD_W = SD_WIDTH
) (
    // clock and control
    input  wire logic            clk_i,
    input  wire logic            rst_i,
    input  wire logic            ce_i,
    // crossing
    input  wire logic            cross_i,
    input  wire logic            trig_i,
    input  wire logic            live_i,
    input  wire logic [SD_W-1:0] setting_i,
    // result
    output logic                 accept_o
);
    logic [SD_W-1:0] count_reg;
    logic [SD_W-1:0] count_next;
    logic            hit;
    logic            reached;

    assign hit        = cross_i && trig_i && live_i;
    assign count_next = count_reg + SD_W'(1);
    assign reached    = (count_next >= setting_i);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_reg <= SD_W'(SD_CNT_RESET);
            accept_o  <= 1'b0;
        end else if (ce_i) begin
            accept_o <= hit && reached;
            if (hit) begin
                count_reg <= reached ? SD_W'(SD_CNT_RESET) : count_next;
            end
        end
    end

    a_dead_not_counted: assert property (
        @(posedge clk_i iff ce_i) disable iff (rst_i)
        cross_i && trig_i && !live_i |=> $stable(count_reg) && !accept_o)
        else $error("trigger counted while busy");
    a_skip_below_n: assert property (
        @(posedge clk_i iff ce_i) disable iff (rst_i)
        hit && !reached |=> !accept_o && count_reg == $past(count_next))
        else $error("accepted before scaledown reached");
    a_reach_accepts: assert property (
        @(posedge clk_i iff ce_i) disable iff (rst_i)
        hit && (count_next >= setting_i) |=> accept_o && count_reg == '0)
        else $error("reached count did not accept and clear");
endmodule : scaledown_path
`default_nettype wire

// [src/trig_pkg.sv]
// Purpose: shared constants and types of the trigger and timing block
// Assumes: 100 MHz system clock
// Notes:   field positions follow the 32-bit schedule entry layout
`default_nettype none
package trig_pkg;
    localparam int CLK_PERIOD_NS  = 10;
    localparam int SEQ_LEN        = 120;
    localparam int NUM_SEQ        = 32;
    localparam int SCHED_DEPTH    = 128;
    localparam int RESTART_BIT    = 31;
    localparam int REPEAT_MSB     = 30;
    localparam int REPEAT_LSB     = 5;
    localparam int SEQ_IDX_MSB    = 4;
    localparam int SEQ_IDX_LSB    = 0;
    localparam int LATENCY_MIN_NS = 4000;
    localparam int LATENCY_MAX_NS = 5000;
    localparam int LATENCY_NS     = 4500;
    localparam int LATENCY_CYC    =
        (LATENCY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BUSY_NS        = 1000;
    localparam int BUSY_CYC       =
        (BUSY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int X6_RATIO       = 6;
    localparam int LINK_PER_XING  = 2 * X6_RATIO;
    localparam int NUM_GRANULES   = 14;
    localparam int GRAN_SEL_W     = 4;
    localparam int NUM_INPUTS     = 8;
    localparam int SD_WIDTH       = 20;
    localparam int MODE_WIDTH     = 4;
    localparam int SD_CNT_RESET   = 0;
    localparam logic [6:0] BUNCH_FIRST = 7'h00;
    localparam logic [6:0] BUNCH_LAST  = 7'h77;
    typedef enum logic {SCH_WAIT, SCH_PLAY} sched_state_type;
endpackage : trig_pkg
`default_nettype wire

// [src/trigger_timing_top.sv]
// Purpose: global trigger decision, scaledown and granule timing units
// Assumes: TRIG_I and SCALEDOWN_I come from logic on CLK_I
// Notes:   beam clock and fiducial pins are filtered by three flops
`default_nettype none
module trigger_timing_top
    import trig_pkg::*;
#(
    parameter int NUM_IN   = NUM_INPUTS,
    parameter int NUM_GRAN = NUM_GRANULES,
    parameter int SD_W     = SD_WIDTH,
    parameter int MW       = MODE_WIDTH
) (
    // system clock, reset and enable
    input  wire logic                   CLK_I,
    input  wire logic                   SYS_RST_I,
    input  wire logic                   CE_I,
    // collider timing pins
    input  wire logic                   BEAM_CLK_I,
    input  wire logic                   FIDUCIAL_I,
    // local trigger boards
    input  wire logic [NUM_IN-1:0]      TRIG_I,
    input  wire logic [NUM_IN*SD_W-1:0] SCALEDOWN_I,
    // acquisition
    input  wire logic                   DAQ_BUSY_I,
    input  wire logic [NUM_GRAN-1:0]    GRAN_EN_I,
    output logic                        BUSY_O,
    output logic                        ACCEPT_O,
    output logic      [31:0]            ACCEPT_COUNT_O,
    output logic      [6:0]             BUNCH_O,
    // scheduler programming
    input  wire logic                   SCHED_WE_I,
    input  wire logic [GRAN_SEL_W-1:0]  SCHED_GRAN_I,
    input  wire logic [6:0]             SCHED_ADDR_I,
    input  wire logic [31:0]            SCHED_WDATA_I,
    output logic      [31:0]            SCHED_RDATA_O,
    input  wire logic                   SEQ_WE_I,
    input  wire logic [4:0]             SEQ_SEL_I,
    input  wire logic [6:0]             SEQ_BUNCH_I,
    input  wire logic [MW-1:0]          SEQ_WDATA_I,
    // link side
    input  wire logic                   LINK_CLK_I,
    output logic                        LINK_BCLK_O,
    output logic                        LINK_X6_O,
    output logic      [NUM_GRAN-1:0]    LINK_ACCEPT_O,
    output logic      [NUM_GRAN-1:0]    LINK_READOUT_O,
    output logic      [NUM_GRAN*MW-1:0] LINK_MODE_O
);
    localparam int LAT = LATENCY_CYC;

    logic [2:0]           beam_sync_reg;
    logic [2:0]           fid_sync_reg;
    logic [2:0]           dbusy_sync_reg;
    logic                 beam_lvl_reg;
    logic                 fid_lvl_reg;
    logic                 dbusy_lvl_reg;
    logic                 beam_rise;
    logic                 fid_filt;
    logic                 started_reg;
    logic [6:0]           bunch_reg;
    logic                 cross_reg;
    logic                 cross_d_reg;
    logic [NUM_IN-1:0]    sd_acc;
    logic                 dec;
    logic                 live;
    logic [7:0]           busy_cnt_reg;
    logic [LAT-1:0]       lat_pipe_reg;
    logic                 issued;
    logic                 pend_reg;
    logic                 acc_now;
    logic [31:0]          sched_rd [NUM_GRAN];
    logic [NUM_GRAN*MW-1:0] mode_all;
    logic                 tgl_reg;
    logic [NUM_GRAN-1:0]  pay_acc_reg;
    logic [NUM_GRAN-1:0]  pay_ro_reg;
    logic [NUM_GRAN*MW-1:0] pay_mode_reg;

    // pin filters: the first flop of each chain feeds only the second
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            beam_sync_reg  <= 3'h0;
            fid_sync_reg   <= 3'h0;
            dbusy_sync_reg <= 3'h0;
            beam_lvl_reg   <= 1'b0;
            fid_lvl_reg    <= 1'b0;
            dbusy_lvl_reg  <= 1'b0;
        end else if (CE_I) begin
            beam_sync_reg  <= {beam_sync_reg[1:0], BEAM_CLK_I};
            fid_sync_reg   <= {fid_sync_reg[1:0], FIDUCIAL_I};
            dbusy_sync_reg <= {dbusy_sync_reg[1:0], DAQ_BUSY_I};
            if (beam_sync_reg[1] == beam_sync_reg[2]) begin
                beam_lvl_reg <= beam_sync_reg[2];
            end
            fid_lvl_reg <= fid_filt;
            if (dbusy_sync_reg[1] == dbusy_sync_reg[2]) begin
                dbusy_lvl_reg <= dbusy_sync_reg[2];
            end
        end
    end

    assign beam_rise = (beam_sync_reg[1] == beam_sync_reg[2]) &&
                       beam_sync_reg[2] && !beam_lvl_reg;
    assign fid_filt  = (fid_sync_reg[1] == fid_sync_reg[2]) ?
                       fid_sync_reg[2] : fid_lvl_reg;

    // bunch counter stays at zero until the first bunch-one tick
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            started_reg <= 1'b0;
            bunch_reg   <= BUNCH_FIRST;
            cross_reg   <= 1'b0;
            cross_d_reg <= 1'b0;
        end else if (CE_I) begin
            cross_reg   <= beam_rise && (fid_filt || started_reg);
            cross_d_reg <= cross_reg;
            if (beam_rise && fid_filt) begin
                started_reg <= 1'b1;
                bunch_reg   <= BUNCH_FIRST;
            end else if (beam_rise && started_reg) begin
                bunch_reg <= (bunch_reg == BUNCH_LAST) ?
                             BUNCH_FIRST : bunch_reg + 7'h01;
            end
        end
    end

    assign BUNCH_O = bunch_reg;
    assign live    = (busy_cnt_reg == 8'h00) && !dbusy_lvl_reg;

    // one counter per input, each of SD_W bits
    for (genvar i = 0; i < NUM_IN; i++) begin : g_sd
        scaledown_path #(
            .SD_W (SD_W)
        ) u_sd (
            .clk_i     (CLK_I),
            .rst_i     (SYS_RST_I),
            .ce_i      (CE_I),
            .cross_i   (cross_reg),
            .trig_i    (TRIG_I[i]),
            .live_i    (live),
            .setting_i (SCALEDOWN_I[i*SD_W +: SD_W]),
            .accept_o  (sd_acc[i])
        );
    end

    assign dec = |sd_acc;

    // busy window opens on the decision, so later crossings are dead time
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            busy_cnt_reg <= 8'h00;
        end else if (CE_I) begin
            if (dec) begin
                busy_cnt_reg <= 8'(BUSY_CYC);
            end else if (busy_cnt_reg != 8'h00) begin
                busy_cnt_reg <= busy_cnt_reg - 8'h01;
            end
        end
    end

    assign BUSY_O = !live;

    // fixed delay line keeps the accept inside the latency window
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            lat_pipe_reg <= '0;
        end else if (CE_I) begin
            lat_pipe_reg <= {lat_pipe_reg[LAT-2:0], dec};
        end
    end

    assign issued   = lat_pipe_reg[LAT-1];
    assign ACCEPT_O = issued;

    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            ACCEPT_COUNT_O <= 32'h0;
        end else if (CE_I && issued && started_reg) begin
            ACCEPT_COUNT_O <= ACCEPT_COUNT_O + 32'h1;
        end
    end

    // granule timing units, one scheduler each
    for (genvar g = 0; g < NUM_GRAN; g++) begin : g_gran
        mode_scheduler #(
            .MW (MW)
        ) u_sched (
            .clk_i       (CLK_I),
            .rst_i       (SYS_RST_I),
            .ce_i        (CE_I),
            .run_i       (started_reg),
            .cross_i     (cross_reg),
            .bunch_i     (bunch_reg),
            .sch_we_i    (SCHED_WE_I &&
                          SCHED_GRAN_I == GRAN_SEL_W'(g)),
            .sch_addr_i  (SCHED_ADDR_I),
            .sch_wdata_i (SCHED_WDATA_I),
            .sch_raddr_i (SCHED_ADDR_I),
            .sch_rdata_o (sched_rd[g]),
            .seq_we_i    (SEQ_WE_I &&
                          SCHED_GRAN_I == GRAN_SEL_W'(g)),
            .seq_sel_i   (SEQ_SEL_I),
            .seq_bunch_i (SEQ_BUNCH_I),
            .seq_wdata_i (SEQ_WDATA_I),
            .mode_o      (mode_all[g*MW +: MW])
        );
    end

    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            SCHED_RDATA_O <= 32'h0;
        end else if (CE_I) begin
            SCHED_RDATA_O <= (SCHED_GRAN_I < GRAN_SEL_W'(NUM_GRAN)) ?
                             sched_rd[SCHED_GRAN_I] : 32'h0;
        end
    end

    // an accept issued between crossings waits for the next frame
    assign acc_now = pend_reg || issued;

    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            pend_reg     <= 1'b0;
            tgl_reg      <= 1'b0;
            pay_acc_reg  <= '0;
            pay_ro_reg   <= '0;
            pay_mode_reg <= '0;
        end else if (CE_I) begin
            if (cross_d_reg) begin
                pend_reg     <= 1'b0;
                tgl_reg      <= !tgl_reg;
                pay_acc_reg  <= {NUM_GRAN{acc_now}};
                pay_ro_reg   <= {NUM_GRAN{acc_now}} & GRAN_EN_I;
                pay_mode_reg <= mode_all;
            end else if (issued) begin
                pend_reg <= 1'b1;
            end
        end
    end

    // link domain: payload is held a whole crossing, far longer than
    // the three-flop toggle detection needs
    logic [2:0]             lrst_sync_reg;
    logic                   link_rst_reg;
    logic [2:0]             tgl_sync_reg;
    logic                   seen_reg;
    logic                   evt;
    logic [3:0]             lcnt_reg;
    logic [3:0]             lcnt_next;

    always_ff @(posedge LINK_CLK_I) begin
        lrst_sync_reg <= {lrst_sync_reg[1:0], SYS_RST_I};
        if (lrst_sync_reg[1] == lrst_sync_reg[2]) begin
            link_rst_reg <= lrst_sync_reg[2];
        end
    end

    assign evt       = (tgl_sync_reg[1] == tgl_sync_reg[2]) &&
                       (tgl_sync_reg[2] != seen_reg);
    assign lcnt_next = (evt || lcnt_reg == 4'(LINK_PER_XING - 1)) ?
                       4'h0 : lcnt_reg + 4'h1;

    always_ff @(posedge LINK_CLK_I) begin
        if (link_rst_reg) begin
            tgl_sync_reg   <= 3'h0;
            seen_reg       <= 1'b0;
            lcnt_reg       <= 4'h0;
            LINK_BCLK_O    <= 1'b0;
            LINK_X6_O      <= 1'b0;
            LINK_ACCEPT_O  <= '0;
            LINK_READOUT_O <= '0;
            LINK_MODE_O    <= '0;
        end else begin
            tgl_sync_reg <= {tgl_sync_reg[1:0], tgl_reg};
            lcnt_reg     <= lcnt_next;
            LINK_BCLK_O  <= lcnt_next < 4'(X6_RATIO);
            LINK_X6_O    <= evt ? 1'b1 : !LINK_X6_O;
            if (evt) begin
                seen_reg       <= tgl_sync_reg[2];
                LINK_ACCEPT_O  <= pay_acc_reg;
                LINK_READOUT_O <= pay_ro_reg;
                LINK_MODE_O    <= pay_mode_reg;
            end
        end
    end

    a_bunch_cycle: assert property (
        @(posedge CLK_I iff CE_I) disable iff (SYS_RST_I)
        beam_rise && started_reg && !fid_filt |=>
        bunch_reg == (($past(bunch_reg) == BUNCH_LAST) ?
                      BUNCH_FIRST : $past(bunch_reg) + 7'h01))
        else $error("bunch number did not step");
    a_hold_until_tick: assert property (
        @(posedge CLK_I iff CE_I) disable iff (SYS_RST_I)
        !started_reg |-> bunch_reg == BUNCH_FIRST && !cross_reg &&
        ACCEPT_COUNT_O == 32'h0)
        else $error("counting before bunch-one tick");
    a_global_or: assert property (
        @(posedge CLK_I iff CE_I) disable iff (SYS_RST_I)
        dec |-> $past(cross_reg) && !$past(dec))
        else $error("global accept not tied to one crossing");
    a_accept_latency: assert property (
        @(posedge CLK_I iff CE_I) disable iff (SYS_RST_I)
        issued == $past(dec, LAT))
        else $error("accept latency wrong");
    a_accept_count: assert property (
        @(posedge CLK_I iff CE_I) disable iff (SYS_RST_I)
        issued && started_reg |=>
        ACCEPT_COUNT_O == $past(ACCEPT_COUNT_O) + 32'h1)
        else $error("accept not counted");
    a_busy_after_dec: assert property (
        @(posedge CLK_I iff CE_I) disable iff (SYS_RST_I)
        dec |=> BUSY_O [*8])
        else $error("busy not held after decision");
    a_pend_kept: assert property (
        @(posedge CLK_I iff CE_I) disable iff (SYS_RST_I)
        issued && cross_d_reg |=> pay_acc_reg == {NUM_GRAN{1'b1}})
        else $error("accept lost at frame load");
    a_link_div: assert property (
        @(posedge LINK_CLK_I) disable iff (link_rst_reg)
        evt |=> LINK_BCLK_O && LINK_X6_O && lcnt_reg == 4'h0)
        else $error("link clocks not aligned to crossing");
endmodule : trigger_timing_top
`default_nettype wire

// [tb/front_end_model.sv]
// Purpose: front-end receiver of one granule's link frames
// Assumes: mode changes every crossing, so a change marks a new frame
// Notes:   counts frames carrying accept and readout for granule 0
`default_nettype none
module front_end_model
    import trig_pkg::*;
(
    // link side
    input  wire logic                    link_clk_i,
    input  wire logic                    bclk_i,
    input  wire logic                    x6_i,
    input  wire logic [NUM_GRANULES-1:0] accept_i,
    input  wire logic [NUM_GRANULES-1:0] readout_i,
    input  wire logic [MODE_WIDTH-1:0]   mode_i,
    // frame tallies
    output logic      [31:0]             acc_frames_o,
    output logic      [31:0]             rd_frames_o,
    output logic      [31:0]             frames_o,
    output logic      [31:0]             clk_bad_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [MODE_WIDTH-1:0] mode_last_reg;
    initial acc_frames_o = 32'h0;
    initial rd_frames_o  = 32'h0;
    initial frames_o     = 32'h0;
    initial clk_bad_o    = 32'h0;
    always @(posedge link_clk_i) begin
        // only a change between two known values marks a frame
        if (mode_i !== mode_last_reg &&
            ^{mode_i, mode_last_reg} !== 1'bx) begin
            frames_o <= frames_o + 32'h1;
            if (!(bclk_i === 1'b1 && x6_i === 1'b1))
                clk_bad_o <= clk_bad_o + 32'h1;
            if (accept_i[0] === 1'b1) acc_frames_o <= acc_frames_o + 32'h1;
            if (readout_i[0] === 1'b1) rd_frames_o <= rd_frames_o + 32'h1;
        end
        mode_last_reg <= mode_i;
    end
endmodule : front_end_model
`default_nettype wire

// [tb/trigger_scaledown_and_mode_scheduler_test.sv]
// Purpose: self-checking bench of the trigger and timing block
// Assumes: crossings 140 cycles apart so the busy window expires
// Notes:   granule 0 plays sequence 0 whose mode is the bunch nibble
`default_nettype none
module trigger_scaledown_and_mode_scheduler_test;
    timeunit 1ns;
    timeprecision 1ps;
    import trig_pkg::*;
    logic clk = 0, lclk = 0, rst = 1, bclk = 0, fid = 0, dbusy = 0;
    logic swe = 0, qwe = 0, busy, acc, lb, lx;
    logic [7:0] trig = 0;
    logic [159:0] sd = '0;
    logic [3:0] gran = 0, qd = 0;
    logic [6:0] addr = 0, qb = 0, bunch;
    logic [4:0] qs = 0;
    logic [31:0] wd = 0, rdata, acnt, fe_acc, fe_rd, fe_fr, fe_bad;
    logic [13:0] la, lr;
    logic [55:0] lm;
    int mismatches = 0, checks_done = 0, cyc = 0, exp_acc = 0;
    int acc_seen = 0;
    int cnt[8] = '{default: 0};

    trigger_timing_top u_dut (.CLK_I(clk), .SYS_RST_I(rst), .CE_I(1'b1),
        .BEAM_CLK_I(bclk), .FIDUCIAL_I(fid), .TRIG_I(trig),
        .SCALEDOWN_I(sd), .DAQ_BUSY_I(dbusy), .GRAN_EN_I(14'h3fff),
        .BUSY_O(busy), .ACCEPT_O(acc), .ACCEPT_COUNT_O(acnt),
        .BUNCH_O(bunch), .SCHED_WE_I(swe), .SCHED_GRAN_I(gran),
        .SCHED_ADDR_I(addr), .SCHED_WDATA_I(wd), .SCHED_RDATA_O(rdata),
        .SEQ_WE_I(qwe), .SEQ_SEL_I(qs), .SEQ_BUNCH_I(qb),
        .SEQ_WDATA_I(qd), .LINK_CLK_I(lclk), .LINK_BCLK_O(lb),
        .LINK_X6_O(lx), .LINK_ACCEPT_O(la), .LINK_READOUT_O(lr),
        .LINK_MODE_O(lm));
    front_end_model u_fe (.link_clk_i(lclk), .bclk_i(lb), .x6_i(lx),
        .accept_i(la), .readout_i(lr), .mode_i(lm[3:0]),
        .acc_frames_o(fe_acc), .rd_frames_o(fe_rd), .frames_o(fe_fr),
        .clk_bad_o(fe_bad));

    initial forever #5 clk = ~clk;

    // accept stands one cycle, so mid-cycle sampling sees it once
    always @(negedge clk) if (acc === 1'b1) acc_seen++;
    initial begin
        #3;
        forever #6 lclk = ~lclk;
    end

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : tally_and_finish

    always @(posedge clk) begin
        cyc <= cyc + 1;
        // ceiling well above the ~20.2k cycles the sequence needs
        if (cyc == 30000) begin
            mismatches++;
            tally_and_finish();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wait_n(input int n);
        repeat (n) @(negedge clk);
    endtask : wait_n

    function automatic logic sd_step(input int i, input logic hit,
                                     input int n);
        if (!hit) return 1'b0;
        cnt[i]++;
        if (cnt[i] >= (n < 1 ? 1 : n)) begin
            cnt[i] = 0;
            return 1'b1;
        end
        return 1'b0;
    endfunction : sd_step

    task automatic crossing(input int k, input logic f, input logic t_on,
                            input logic model);
        logic any;
        any = 1'b0;
        trig = t_on ? 8'($urandom) : 8'h00;
        dbusy = ($urandom % 4) == 0;
        fid = f;
        wait_n(10);
        bclk = 1'b1;
        wait_n(7);
        bclk = 1'b0;
        fid = 1'b0;
        // crossings before the first tick are never counted
        if (model) begin
            for (int i = 0; i < 8; i++)
                any |= sd_step(i, trig[i] && !dbusy, int'(sd[i*20+:20]));
            if (any) exp_acc++;
            chk(32'(busy), 32'(any || dbusy));
        end
        wait_n(118);
        if (model) begin
            chk(32'(bunch), 32'(k % 120));
            chk(32'(lm[3:0]), 32'((k % 120) % 16));
            chk(32'(busy), 32'(dbusy));
        end
        wait_n(5);
    endtask : crossing

    initial begin
        void'($urandom(83899));
        sd[0+:20] = 20'h00001;
        sd[20+:20] = 20'h00003;
        sd[60+:20] = 20'h51615;
        for (int i = 4; i < 8; i++) sd[i*20+:20] = 20'(2 + $urandom % 6);
        wait_n(8);
        rst = 1'b0;
        qwe = 1'b1;
        for (int b = 0; b < 120; b++) begin
            qb = 7'(b);
            qd = 4'(b);
            wait_n(1);
        end
        qwe = 1'b0;
        wd = {1'b1, 26'h1, 5'h00};
        swe = 1'b1;
        // every granule gets a known entry so no scheduler runs on junk
        for (int g = 13; g >= 0; g--) begin
            gran = 4'(g);
            wait_n(1);
        end
        swe = 1'b0;
        wait_n(2);
        chk(rdata, wd);
        gran = 4'he;
        swe = 1'b1;
        wait_n(1);
        swe = 1'b0;
        wait_n(2);
        chk(rdata, 32'h0);
        gran = 4'h0;
        for (int k = 0; k < 3; k++) crossing(k, 1'b0, 1'b1, 1'b0);
        chk(32'(bunch), 32'h0);
        chk(acnt, 32'h0);
        for (int k = 0; k < 140; k++) crossing(k, k == 0, k < 130, 1'b1);
        chk(acnt, 32'(exp_acc));
        chk(fe_acc, 32'(exp_acc));
        chk(fe_rd, 32'(exp_acc));
        chk(32'(acc_seen), 32'(exp_acc));
        chk(fe_fr, 32'h8b);
        chk(fe_bad, 32'h0);
        tally_and_finish();
    end
endmodule : trigger_scaledown_and_mode_scheduler_test
`default_nettype wire
